// file: core/irq_map_defs.vh
// constants for the interrupt request map and vector fetch logic
// assumes a single 20 MHz machine clock and synchronous active-low reset
`ifndef IRQ_MAP_DEFS_VH
`define IRQ_MAP_DEFS_VH

`define REQ_COUNT        24
`define REQ_NUM_W        5
`define LEVEL_W          2
`define LEVEL_BUS_W      48
`define LEVEL_LOWEST     2'h3

`define VEC_BASE_ADDR    16'hFFCC
`define VEC_TOP_ADDR     16'hFFFB
`define VEC_UPPER_REQ0   6'h2E
`define VEC_TABLE_BYTES  48
`define VEC_INDEX_W      6

`define PERIPH_ADDR_W    12
`define DIS_A_LO         12'hFE0
`define DIS_A_HI         12'hFE1
`define DIS_B_LO         12'hFE6
`define DIS_B_HI         12'hFE7
`define DIS_C            12'hFED
`define DIS_D_LO         12'hFF0
`define DIS_D_HI         12'hFFF
`define UNDEF_READ_VALUE 8'h00

`define ST_IDLE          2'h0
`define ST_READ_UPPER    2'h1
`define ST_READ_LOWER    2'h2
`define ST_DELIVER       2'h3

`endif

// file: core/vector_table_mem.v
// byte memory holding the 48-byte interrupt vector table
// assumes the caller keeps indices below the table size
`timescale 1ns/1ps
`include "irq_map_defs.vh"

module vector_table_mem (
  input  wire                      clk,
  input  wire                      wr_en,
  input  wire [`VEC_INDEX_W-1:0]   wr_index,
  input  wire [7:0]                wr_data,
  input  wire                      rd_en,
  input  wire [`VEC_INDEX_W-1:0]   rd_index,
  output reg  [7:0]                rd_data
);

  reg [7:0] mem [0:`VEC_TABLE_BYTES-1];

  // contents are not reset; the loader fills the table before use
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_index] <= wr_data;
    end
    if (rd_en) begin
      rd_data <= mem[rd_index];
    end
  end

endmodule

// file: core/interrupt_vector_priority_map.v
// interrupt request map: merges peripheral sources onto 24 requests,
// arbitrates by level and number, fetches the two-byte handler vector
// assumes level fields and sources are synchronous to clk
`timescale 1ns/1ps
`include "irq_map_defs.vh"

// Summary of operation
// RULE_01 - There are 24 requests and request n has its vector upper byte at FFFA minus 2n and lower byte one above.
// RULE_02 - Every request has its own two-bit level field, request n using field n of the level bus.
// RULE_03 - Among pending requests of the same level the lowest request number is served first.
// RULE_04 - External channels 0/4, 1/5, 2/6, 3/7 share requests 0 to 3 and channels 8 and 9 share request 21.
// RULE_05 - Request 4 is the OR of the clocked serial channel 0 and the dead-time trip input interrupts.
// RULE_06 - Request 16 merges reload timer 1, the write-timing and compare-clear events and the I2C interrupt.
// RULE_07 - Request 17 merges the programmable pulse generator with the position-detection and compare-match events.
// RULE_08 - A read of an unimplemented peripheral address returns a value and raises no error.
// RULE_09 - Software must never write to an unimplemented peripheral address such as 0FE0 to 0FE1.
// RULE_10 - The handler address takes the upper vector byte as its high half and the lower byte as its low half.
module interrupt_vector_priority_map (
  input  wire                       clk,
  input  wire                       rstn,
  input  wire [9:0]                 ext_int,
  input  wire                       clocked_serial_channel_irq,
  input  wire                       dead_time_trip_input_irq,
  input  wire                       comp_timer0_lo_irq,
  input  wire                       comp_timer0_hi_irq,
  input  wire                       lin_rx_irq,
  input  wire                       lin_tx_irq,
  input  wire                       pulse_gen1_lo_irq,
  input  wire                       pulse_gen1_hi_irq,
  input  wire                       pulse_gen2_hi_irq,
  input  wire                       pulse_gen0_hi_irq,
  input  wire                       pulse_gen0_lo_irq,
  input  wire                       comp_timer1_hi_irq,
  input  wire                       pulse_gen2_lo_irq,
  input  wire                       reload_timer1_irq,
  input  wire                       write_timing_irq,
  input  wire                       compare_clear_irq,
  input  wire                       i2c_irq,
  input  wire                       programmable_pulse_generator_irq,
  input  wire                       position_detect_irq,
  input  wire                       compare_match_irq,
  input  wire                       adc_irq,
  input  wire                       time_base_irq,
  input  wire                       watch_prescaler_irq,
  input  wire                       comp_timer1_lo_irq,
  input  wire                       flash_irq,
  input  wire [`LEVEL_BUS_W-1:0]    level_fields,
  input  wire                       irq_ack,
  input  wire                       vec_wr_en,
  input  wire [15:0]                vec_wr_addr,
  input  wire [7:0]                 vec_wr_data,
  input  wire                       periph_rd,
  input  wire                       periph_wr,
  input  wire [`PERIPH_ADDR_W-1:0]  periph_addr,
  output reg                        irq_req,
  output reg  [`REQ_NUM_W-1:0]      irq_num,
  output reg  [`LEVEL_W-1:0]        irq_level,
  output reg                        fetch_busy,
  output reg                        vector_valid,
  output reg  [`REQ_NUM_W-1:0]      vector_num,
  output reg  [15:0]                handler_addr,
  output reg  [7:0]                 periph_rd_data,
  output reg                        disabled_rd,
  output reg                        disabled_wr
);

  wire [`REQ_COUNT-1:0]   req;
  reg  [1:0]              state;
  reg  [1:0]              next_state;
  reg  [`REQ_NUM_W-1:0]   sel_num;
  reg  [7:0]              upper_byte;
  reg                     best_found;
  reg  [`REQ_NUM_W-1:0]   best_num;
  reg  [`LEVEL_W-1:0]     best_lvl;
  reg                     mem_rd_en;
  reg  [`VEC_INDEX_W-1:0] mem_rd_index;
  wire [7:0]              mem_rd_data;
  wire                    vec_in_range;
  wire [15:0]             vec_offset;
  integer                 n;

  // table index of a request's vector byte: upper at 46-2n, lower above
  function [`VEC_INDEX_W-1:0] vec_index;
    input [`REQ_NUM_W-1:0] num;
    input                  lower;
    begin
      vec_index = `VEC_UPPER_REQ0 - {num, 1'b0} + {5'h00, lower}; // RULE_01
    end
  endfunction

  // unimplemented peripheral addresses in this stretch of the map
  function is_disabled;
    input [`PERIPH_ADDR_W-1:0] a;
    begin
      is_disabled = (a >= `DIS_A_LO && a <= `DIS_A_HI) ||
                    (a >= `DIS_B_LO && a <= `DIS_B_HI) ||
                    (a == `DIS_C) ||
                    (a >= `DIS_D_LO && a <= `DIS_D_HI);
    end
  endfunction

  // source merging onto request lines
  assign req[0]  = ext_int[0] | ext_int[4]; // RULE_04
  assign req[1]  = ext_int[1] | ext_int[5]; // RULE_04
  assign req[2]  = ext_int[2] | ext_int[6]; // RULE_04
  assign req[3]  = ext_int[3] | ext_int[7]; // RULE_04
  assign req[4]  = clocked_serial_channel_irq |
                   dead_time_trip_input_irq; // RULE_05
  assign req[5]  = comp_timer0_lo_irq;
  assign req[6]  = comp_timer0_hi_irq;
  assign req[7]  = lin_rx_irq;
  assign req[8]  = lin_tx_irq;
  assign req[9]  = pulse_gen1_lo_irq;
  assign req[10] = pulse_gen1_hi_irq;
  assign req[11] = pulse_gen2_hi_irq;
  assign req[12] = pulse_gen0_hi_irq;
  assign req[13] = pulse_gen0_lo_irq;
  assign req[14] = comp_timer1_hi_irq;
  assign req[15] = pulse_gen2_lo_irq;
  assign req[16] = reload_timer1_irq | write_timing_irq |
                   compare_clear_irq | i2c_irq; // RULE_06
  assign req[17] = programmable_pulse_generator_irq |
                   position_detect_irq | compare_match_irq; // RULE_07
  assign req[18] = adc_irq;
  assign req[19] = time_base_irq;
  assign req[20] = watch_prescaler_irq;
  assign req[21] = ext_int[8] | ext_int[9]; // RULE_04
  assign req[22] = comp_timer1_lo_irq;
  assign req[23] = flash_irq;

  // lower level value is more urgent; scanning downward with <= lets
  // the lower number win a tie
  always @* begin
    best_found = 1'b0;
    best_num   = {`REQ_NUM_W{1'b0}};
    best_lvl   = `LEVEL_LOWEST;
    for (n = `REQ_COUNT - 1; n >= 0; n = n - 1) begin
      if (req[n] &&
          (!best_found ||
           level_fields[2*n +: 2] <= best_lvl)) begin // RULE_02 RULE_03
        best_found = 1'b1;
        best_num   = n[`REQ_NUM_W-1:0];
        best_lvl   = level_fields[2*n +: 2]; // RULE_02
      end
    end
  end

  always @* begin
    next_state   = state;
    mem_rd_en    = 1'b0;
    mem_rd_index = vec_index(sel_num, 1'b0);
    case (state)
      `ST_IDLE: begin
        if (irq_ack && irq_req) begin
          next_state = `ST_READ_UPPER;
        end
      end
      `ST_READ_UPPER: begin
        mem_rd_en    = 1'b1;
        mem_rd_index = vec_index(sel_num, 1'b0); // RULE_01
        next_state   = `ST_READ_LOWER;
      end
      `ST_READ_LOWER: begin
        mem_rd_en    = 1'b1;
        mem_rd_index = vec_index(sel_num, 1'b1); // RULE_01
        next_state   = `ST_DELIVER;
      end
      `ST_DELIVER: begin
        next_state = `ST_IDLE;
      end
      default: begin
        next_state = `ST_IDLE;
      end
    endcase
  end

  assign vec_offset   = vec_wr_addr - `VEC_BASE_ADDR;
  assign vec_in_range = (vec_wr_addr >= `VEC_BASE_ADDR) &&
                        (vec_wr_addr <= `VEC_TOP_ADDR);

  vector_table_mem u_table (
    .clk      (clk),
    .wr_en    (vec_wr_en && vec_in_range),
    .wr_index (vec_offset[`VEC_INDEX_W-1:0]),
    .wr_data  (vec_wr_data),
    .rd_en    (mem_rd_en),
    .rd_index (mem_rd_index),
    .rd_data  (mem_rd_data)
  );

  always @(posedge clk) begin
    if (!rstn) begin
      state        <= `ST_IDLE;
      sel_num      <= {`REQ_NUM_W{1'b0}};
      upper_byte   <= 8'h00;
      irq_req      <= 1'b0;
      irq_num      <= {`REQ_NUM_W{1'b0}};
      irq_level    <= {`LEVEL_W{1'b0}};
      fetch_busy   <= 1'b0;
      vector_valid <= 1'b0;
      vector_num   <= {`REQ_NUM_W{1'b0}};
      handler_addr <= 16'h0000;
    end else begin
      state        <= next_state;
      vector_valid <= 1'b0;
      fetch_busy   <= (next_state != `ST_IDLE);
      // request is withheld while a vector is being fetched
      irq_req      <= best_found && (next_state == `ST_IDLE);
      irq_num      <= best_num;
      irq_level    <= best_lvl;
      if (state == `ST_IDLE && irq_ack && irq_req) begin
        sel_num <= irq_num;
      end
      if (state == `ST_READ_LOWER) begin
        upper_byte <= mem_rd_data;
      end
      if (state == `ST_DELIVER) begin
        handler_addr <= {upper_byte, mem_rd_data}; // RULE_10
        vector_num   <= sel_num;
        vector_valid <= 1'b1;
      end
    end
  end

  // the functional registers of this range live in other units; only
  // the disabled holes answer here
  always @(posedge clk) begin
    if (!rstn) begin
      periph_rd_data <= 8'h00;
      disabled_rd    <= 1'b0;
      disabled_wr    <= 1'b0;
    end else begin
      disabled_rd <= periph_rd && is_disabled(periph_addr); // RULE_08
      disabled_wr <= periph_wr && is_disabled(periph_addr); // RULE_09
      if (periph_rd && is_disabled(periph_addr)) begin
        periph_rd_data <= `UNDEF_READ_VALUE; // RULE_08
      end
    end
  end

endmodule

// file: bench/irq_map_props.sv
// concurrent checks on the interrupt map ports
// assumes one clock domain and synchronous active-low reset
`timescale 1ns/1ps
`include "irq_map_defs.vh"
module irq_map_props (
  input wire                      clk,
  input wire                      rstn,
  input wire                      clocked_serial_channel_irq,
  input wire                      dead_time_trip_input_irq,
  input wire [`LEVEL_BUS_W-1:0]   level_fields,
  input wire                      irq_ack,
  input wire                      periph_rd,
  input wire                      periph_wr,
  input wire [`PERIPH_ADDR_W-1:0] periph_addr,
  input wire                      irq_req,
  input wire [`REQ_NUM_W-1:0]     irq_num,
  input wire [`LEVEL_W-1:0]       irq_level,
  input wire                      fetch_busy,
  input wire                      vector_valid,
  input wire [`REQ_NUM_W-1:0]     vector_num,
  input wire [15:0]               handler_addr,
  input wire [7:0]                periph_rd_data,
  input wire                      disabled_rd,
  input wire                      disabled_wr
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  wire hole = periph_addr == 12'hFE0 || periph_addr == 12'hFE1 ||
    periph_addr == 12'hFE6 || periph_addr == 12'hFE7 ||
    periph_addr == 12'hFED || periph_addr >= 12'hFF0;
  wire take = irq_req && irq_ack;
  a_fetch_timing: assert property (take |=> fetch_busy [*3] ##1
    (!fetch_busy && vector_valid)) else $error("fetch timing wrong");
  a_vector_number: assert property (take |-> ##4
    vector_num == $past(irq_num, 4)) else $error("vector number wrong");
  a_busy_holds_req: assert property (fetch_busy |-> !irq_req)
    else $error("request shown during fetch");
  a_req4_merge: assert property ($past(rstn) && !fetch_busy && !irq_ack &&
    (clocked_serial_channel_irq || dead_time_trip_input_irq) |=> irq_req)
    else $error("merged source not raised");
  a_level_field: assert property (irq_req |-> irq_level ==
    2'($past(level_fields) >> {irq_num, 1'b0})) else $error("level wrong");
  a_hole_read: assert property (periph_rd && hole |=> disabled_rd &&
    periph_rd_data == 8'h00) else $error("hole read wrong");
  a_hole_write: assert property (periph_wr && hole |=> disabled_wr)
    else $error("hole write not flagged");
  a_no_false_read: assert property (!(periph_rd && hole) |=> !disabled_rd)
    else $error("false hole read flag");
  a_valid_pulse: assert property (vector_valid |=> !vector_valid)
    else $error("vector valid too long");
  a_handler_hold: assert property ($past(rstn) && !vector_valid |->
    $stable(handler_addr)) else $error("handler address moved");
endmodule

// file: bench/cpu_core_model.sv
// behavioural core that accepts requests and collects handler vectors
// assumes irq_ack is sampled on the same rising edge as irq_req
`timescale 1ns/1ps
module cpu_core_model (
  input  wire        clk,
  input  wire        irq_req,
  input  wire        vector_valid,
  input  wire [15:0] handler_addr,
  input  wire [4:0]  vector_num,
  input  wire [7:0]  want,
  input  wire [3:0]  delay,
  output reg         irq_ack,
  output reg  [7:0]  served,
  output reg  [15:0] got_addr,
  output reg  [4:0]  got_num
);
  reg       wait_vec;
  reg [3:0] waitc;
  initial begin
    {irq_ack, served, got_addr, got_num, wait_vec, waitc} = 0;
  end
  // never writes peripheral space; only acks and collects
  always @(posedge clk) begin
    if (vector_valid) begin
      served <= served + 8'h01;
      got_addr <= handler_addr;
      got_num <= vector_num;
      wait_vec <= 1'b0;
    end
    if (irq_ack && irq_req) begin
      irq_ack <= 1'b0;
      wait_vec <= 1'b1;
    end else if (!irq_ack && !wait_vec && !vector_valid && irq_req &&
                 served != want) begin
      // slow answers wait delay cycles before acking
      if (waitc >= delay) begin
        irq_ack <= 1'b1;
        waitc <= 4'h0;
      end else
        waitc <= waitc + 4'h1;
    end
  end
endmodule

// file: bench/tb_top.sv
// self-checking bench for the interrupt map with a core model
// assumes 20 MHz clock, inputs driven 1 ns after the rising edge
`timescale 1ns/1ps
`include "irq_map_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %0h got %0h", n, e, g); end end
module tb_top;
  reg         clk = 0, rstn = 0, vec_wr_en = 0, periph_rd = 0, periph_wr = 0;
  reg  [9:0]  ext_int = 0;
  reg  [24:0] src = 0;
  reg  [47:0] level_fields = 0;
  reg  [15:0] vec_wr_addr = 0;
  reg  [7:0]  vec_wr_data = 0, want = 0;
  reg  [11:0] periph_addr = 0;
  reg  [3:0]  delay = 0;
  wire        irq_ack, irq_req, fetch_busy, vector_valid;
  wire        disabled_rd, disabled_wr;
  wire [4:0]  irq_num, vector_num, got_num;
  wire [1:0]  irq_level;
  wire [15:0] handler_addr, got_addr;
  wire [7:0]  periph_rd_data, served;
  integer     errors = 0, tests_run = 0, cycles = 0;
  interrupt_vector_priority_map interrupt_vector_priority_map_inst (
    .clk(clk), .rstn(rstn), .ext_int(ext_int), .level_fields(level_fields),
    .irq_ack(irq_ack), .vec_wr_en(vec_wr_en), .vec_wr_addr(vec_wr_addr),
    .vec_wr_data(vec_wr_data), .periph_rd(periph_rd),
    .periph_wr(periph_wr), .periph_addr(periph_addr), .irq_req(irq_req),
    .irq_num(irq_num), .irq_level(irq_level), .fetch_busy(fetch_busy),
    .vector_valid(vector_valid), .vector_num(vector_num),
    .handler_addr(handler_addr), .periph_rd_data(periph_rd_data),
    .disabled_rd(disabled_rd), .disabled_wr(disabled_wr),
    .clocked_serial_channel_irq(src[0]), .dead_time_trip_input_irq(src[1]),
    .comp_timer0_lo_irq(src[2]), .comp_timer0_hi_irq(src[3]),
    .lin_rx_irq(src[4]), .lin_tx_irq(src[5]), .pulse_gen1_lo_irq(src[6]),
    .pulse_gen1_hi_irq(src[7]), .pulse_gen2_hi_irq(src[8]),
    .pulse_gen0_hi_irq(src[9]), .pulse_gen0_lo_irq(src[10]),
    .comp_timer1_hi_irq(src[11]), .pulse_gen2_lo_irq(src[12]),
    .reload_timer1_irq(src[13]), .write_timing_irq(src[14]),
    .compare_clear_irq(src[15]), .i2c_irq(src[16]),
    .programmable_pulse_generator_irq(src[17]),
    .position_detect_irq(src[18]), .compare_match_irq(src[19]),
    .adc_irq(src[20]), .time_base_irq(src[21]),
    .watch_prescaler_irq(src[22]), .comp_timer1_lo_irq(src[23]),
    .flash_irq(src[24]));
  cpu_core_model cpu_core_model_inst (.clk(clk), .irq_req(irq_req),
    .vector_valid(vector_valid), .handler_addr(handler_addr),
    .vector_num(vector_num), .want(want), .delay(delay), .irq_ack(irq_ack),
    .served(served), .got_addr(got_addr), .got_num(got_num));
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 5000) begin
      errors = errors + 1;
      tally_and_finish;
    end
  end
  function [4:0] req_of(input integer k);
    req_of = k < 2 ? 4 : k < 13 ? k + 3 : k < 17 ? 16 : k < 20 ? 17 :
      k < 23 ? k - 2 : k - 1;
  endfunction
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  task fetch(input [4:0] n);
    integer w;
    begin
      want = served + 8'h01;
      for (w = 0; w < 40 && served != want; w = w + 1) tick;
      // a lost delivery would otherwise pass on a stale shared number
      `CHK("served", want, served)
      `CHK("vector_num", n, got_num)
      `CHK("handler_addr", {3'h0, n, 8'hA0 + {3'h0, n}}, got_addr)
    end
  endtask
  task load_table;
    integer n;
    begin
      vec_wr_en = 1;
      for (n = 0; n < 24; n = n + 1) begin
        vec_wr_addr = 16'hFFFA - 2 * n;
        vec_wr_data = n;
        tick;
        vec_wr_addr = 16'hFFFB - 2 * n;
        vec_wr_data = 8'hA0 + n;
        tick;
      end
      // outside the table, must be dropped
      vec_wr_addr = 16'hFFFC;
      tick;
      vec_wr_en = 0;
    end
  endtask
  task t_sources;
    integer k;
    begin
      for (k = 0; k < 35; k = k + 1) begin
        delay = k % 4;
        if (k < 25) src = 25'h1 << k;
        else ext_int = 10'h1 << (k - 25);
        fetch(k < 25 ? req_of(k) : k < 33 ? (k - 25) % 4 : 21);
        src = 0;
        ext_int = 0;
        tick;
        tick;
      end
    end
  endtask
  task t_priority;
    begin
      src = 25'h1800000;
      ext_int = 10'h300;
      tick;
      tick;
      `CHK("irq_num", 5'd21, irq_num)
      level_fields[47:42] = 6'h17;
      tick;
      tick;
      `CHK("irq_num", 5'd22, irq_num)
      `CHK("irq_level", 2'h1, irq_level)
      src = 25'h1FFFFFF;
      ext_int = 10'h3FF;
      level_fields = {2'h2, 46'h3FFFFFFFFFFF};
      tick;
      tick;
      `CHK("irq_num", 5'd23, irq_num)
      level_fields = 0;
      tick;
      tick;
      `CHK("irq_num", 5'd0, irq_num)
      src = 0;
      ext_int = 0;
      tick;
    end
  endtask
  task t_holes;
    integer k;
    reg [11:0] a;
    reg h;
    begin
      for (k = 0; k < 20; k = k + 1) begin
        a = 12'hFDE + k;
        h = a == 12'hFE0 || a == 12'hFE1 || a == 12'hFE6 || a == 12'hFE7 ||
          a == 12'hFED || a >= 12'hFF0;
        periph_addr = a;
        periph_rd = 1;
        tick;
        `CHK("disabled_rd", h, disabled_rd)
        if (h) `CHK("periph_rd_data", 8'h00, periph_rd_data)
        periph_rd = 0;
        periph_wr = 1;
        tick;
        `CHK("disabled_wr", h, disabled_wr)
        periph_wr = 0;
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rstn = 1;
    tick;
    tick;
    `CHK("handler_addr", 16'h0000, handler_addr)
    load_table;
    t_sources;
    t_priority;
    t_holes;
    // reset again mid-run; table memory keeps its bytes
    rstn = 0;
    tick;
    `CHK("handler_addr", 16'h0000, handler_addr)
    rstn = 1;
    src = 25'h2;
    fetch(5'd4);
    tally_and_finish;
  end
endmodule
bind interrupt_vector_priority_map irq_map_props irq_map_props_inst (
  .clk(clk), .rstn(rstn),
  .clocked_serial_channel_irq(clocked_serial_channel_irq),
  .dead_time_trip_input_irq(dead_time_trip_input_irq),
  .level_fields(level_fields), .irq_ack(irq_ack), .periph_rd(periph_rd),
  .periph_wr(periph_wr), .periph_addr(periph_addr), .irq_req(irq_req),
  .irq_num(irq_num), .irq_level(irq_level), .fetch_busy(fetch_busy),
  .vector_valid(vector_valid), .vector_num(vector_num),
  .handler_addr(handler_addr), .periph_rd_data(periph_rd_data),
  .disabled_rd(disabled_rd), .disabled_wr(disabled_wr));
